//--- rtl/syc_pkg.sv
/*
  Constants, field positions and types shared by the synchronous serial
  channel core and its testbench.
  Assumes a single 40 MHz system clock and a plain register port with
  3-bit word addresses and 16-bit data.
*/
// What this block does
// RULE1: Full-duplex or half-duplex transfers, selectable.
// RULE2: Character length two to sixteen bits.
// RULE3: Master makes shift clock; slave follows it.
// RULE4: Bit order LSB-first or MSB-first.
// RULE5: Programmable clock idle level, held between transfers.
// RULE6: Programmable phase: shift and latch edges.
// RULE7: Baud generator, 20 Mbit/s to 305.18 bit/s.
// RULE8: Flag transmit and receive buffer mishandling errors.
// RULE9: Flag phase and baud-rate errors on link.
// RULE10: Separate transmit, receive and error interrupts.
// RULE11: Interrupt on empty, full and any error.
// RULE12: Loop-back routes transmit data to receiver.
// RULE13: Three pins with configurable data pin assignment.
// RULE14: Interoperates with standard SPI masters and slaves.
// RULE15: Master starts on buffer write; receive at end.
// RULE16: Error flags stay set until software clears.
package syc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register word addresses.
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_BAUD = 3'h1;
  localparam logic [2:0] A_TXB  = 3'h2;
  localparam logic [2:0] A_RXB  = 3'h3;
  localparam logic [2:0] A_FLAG = 3'h4;
  localparam logic [2:0] A_MASK = 3'h5;
  localparam logic [2:0] A_STAT = 3'h6;

  //////////////////////////////////////////////////////////////////////////
  // Control register fields.
  localparam int C_LEN   = 0;
  localparam int C_MSB   = 4;
  localparam int C_PHASE = 5;
  localparam int C_POL   = 6;
  localparam int C_MST   = 7;
  localparam int C_EN    = 8;
  localparam int C_LOOP  = 9;
  localparam int C_HALF  = 10;
  localparam int C_SWAP  = 11;

  // Event flag and mask fields.
  localparam int F_TXE = 0;
  localparam int F_RXF = 1;
  localparam int F_TE  = 2;
  localparam int F_RE  = 3;
  localparam int F_PE  = 4;
  localparam int F_BE  = 5;
  localparam int F_W   = 6;

  //////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0]    CTRL_RST = 16'h0007;
  localparam logic [15:0]    BAUD_RST = 16'h0009;
  localparam logic [F_W-1:0] MASK_RST = 6'h00;

  // Timing: fastest bit rate gives a half period of one system clock.
  localparam int SYS_HZ       = 40_000_000;
  localparam int MAX_BPS      = 20_000_000;
  localparam int HALF_MIN_CYC = SYS_HZ / (2 * MAX_BPS);

  // Shifter state.
  typedef enum logic {SH_IDLE, SH_RUN} syc_shift_t;

endpackage

//--- rtl/syc_baud.sv
/*
  Baud-rate generator: emits a one-cycle tick every reload+1 clocks while
  run is high, one tick per half period of the shift clock.
  Assumes reload is stable while run is high.
*/
`timescale 1ns/10ps
module syc_baud
#(
  parameter int W = 16
)
(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         run,
  input  wire logic [W-1:0] reload,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } syc_baud_t;

  syc_baud_t s_q;
  syc_baud_t s_d;

  // Down-counter reloads on each tick and holds reload while stopped.
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run)
      s_d.cnt = reload;
    else if (s_q.cnt == '0)
    begin
      s_d.cnt  = reload;
      s_d.tick = 1'b1; // RULE7
    end
    else
      s_d.cnt = W'(s_q.cnt - 1'b1);
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

  // Ticks are never closer than the fastest half period.
  tick_space_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_q.tick && reload != '0 |=> !s_q.tick) else $error("tick too early"); // RULE7

endmodule

//--- rtl/syc_channel.sv
/*
  Synchronous serial channel: master or slave shifter with programmable
  length, order, polarity and phase, a register port and three interrupts.
  Assumes pins arrive asynchronously and pass a three-stage synchroniser;
  the pad logic resolves each pin from its output enable.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module syc_channel
#(
  parameter int BRW = 16
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  output logic             irq_tx,
  output logic             irq_rx,
  output logic             irq_err,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  input  wire logic        pa_i,
  output logic             pa_o,
  output logic             pa_oe,
  input  wire logic        pb_i,
  output logic             pb_o,
  output logic             pb_oe
);

  //////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [15:0]          ctrl;
    logic [BRW-1:0]       baud;
    logic [15:0]          txb;
    logic [15:0]          rxb;
    logic [syc_pkg::F_W-1:0] flag;
    logic [syc_pkg::F_W-1:0] mask;
    logic                 tb_full;
    logic                 rb_full;
    logic                 loaded;
    syc_pkg::syc_shift_t  st;
    logic [4:0]           edge_k;
    logic [15:0]          sr;
    logic [15:0]          rx;
    logic                 sclk_lvl;
    logic [BRW-1:0]       hp;
    logic [2:0]           ck_s;
    logic [2:0]           da_s;
    logic [2:0]           db_s;
    logic                 ck_f;
    logic                 da_f;
    logic                 db_f;
    logic [15:0]          rdata;
    logic                 irq_tx;
    logic                 irq_rx;
    logic                 irq_err;
    logic                 sclk_o;
    logic                 sclk_oe;
    logic                 pa_o;
    logic                 pa_oe;
    logic                 pb_o;
    logic                 pb_oe;
  } syc_state_t;

  syc_state_t s_q;
  syc_state_t s_d;
  logic       tick;
  logic       done;

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Inserts a received bit so the character lands in the low bits.
  function automatic logic [15:0] shift_in(input logic [15:0] r, input logic b,
                                           input logic [3:0] lm1, input logic msb);
    logic [15:0] t;
    t = '0;
    if (msb)
      t = {r[14:0], b};
    else
    begin
      t      = r >> 1;
      t[lm1] = b;
    end
    return t;
  endfunction

  // Bit presented on the line for the current shift register content.
  function automatic logic tx_bit(input logic [15:0] r, input logic [3:0] lm1, input logic msb);
    return msb ? r[lm1] : r[0];
  endfunction

  // Control fields.
  logic [3:0] lm1_w;
  logic       msb_w;
  logic       ph_w;
  logic       pol_w;
  logic       mst_w;
  logic       en_w;
  logic       lb_w;
  logic       hd_w;
  logic       swap_w;
  logic [4:0] last_k;

  // A length field below one is read as two-bit characters.
  assign lm1_w  = (s_q.ctrl[syc_pkg::C_LEN +: 4] == 4'h0) ? 4'h1 : s_q.ctrl[syc_pkg::C_LEN +: 4]; // RULE2
  assign msb_w  = s_q.ctrl[syc_pkg::C_MSB];
  assign ph_w   = s_q.ctrl[syc_pkg::C_PHASE];
  assign pol_w  = s_q.ctrl[syc_pkg::C_POL];
  assign mst_w  = s_q.ctrl[syc_pkg::C_MST];
  assign en_w   = s_q.ctrl[syc_pkg::C_EN];
  assign lb_w   = s_q.ctrl[syc_pkg::C_LOOP];
  assign hd_w   = s_q.ctrl[syc_pkg::C_HALF];
  assign swap_w = s_q.ctrl[syc_pkg::C_SWAP];
  assign last_k = {lm1_w, 1'b1}; // RULE2

  // Baud generator runs only while a master transfer is in flight.
  syc_baud #(
    .W (BRW)
  ) u_baud (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (en_w && mst_w && s_q.st == syc_pkg::SH_RUN),
    .reload  (s_q.baud),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    logic [syc_pkg::F_W-1:0] set;
    logic [syc_pkg::F_W-1:0] clr;
    logic [4:0] k;
    logic       ev;
    logic       ck_edge;
    logic       rxbit;
    logic       din_chg;
    logic       latch;
    logic       shf;
    logic       tb;
    logic       drv;
    logic       own;
    set     = '0;
    clr     = '0;
    rxbit   = 1'b0;
    ck_edge = 1'b0;
    din_chg = 1'b0;
    tb      = 1'b0;
    drv     = 1'b0;
    own     = 1'b0;
    k       = s_q.edge_k;
    ev      = 1'b0;
    latch   = 1'b0;
    shf     = 1'b0;
    done    = 1'b0;
    s_d       = s_q;
    s_d.rdata = '0;

    // Three-stage synchronisers; a level counts once stages two and three agree.
    s_d.ck_s = {s_q.ck_s[1:0], sclk_i};
    s_d.da_s = {s_q.da_s[1:0], pa_i};
    s_d.db_s = {s_q.db_s[1:0], pb_i};
    if (s_q.ck_s[2] == s_q.ck_s[1])
      s_d.ck_f = s_q.ck_s[2];
    if (s_q.da_s[2] == s_q.da_s[1])
      s_d.da_f = s_q.da_s[2];
    if (s_q.db_s[2] == s_q.db_s[1])
      s_d.db_f = s_q.db_s[2];
    ck_edge = (s_d.ck_f != s_q.ck_f);

    // Receive source: own transmit bit in loop-back, own line in half duplex, the other line otherwise.
    if (lb_w)
      rxbit = tx_bit(s_q.sr, lm1_w, msb_w); // RULE12
    else if ((mst_w ^ hd_w) ^ swap_w)
      rxbit = s_q.db_f; // RULE13
    else
      rxbit = s_q.da_f; // RULE1
    din_chg = ((mst_w ^ hd_w) ^ swap_w) ? (s_d.db_f != s_q.db_f) : (s_d.da_f != s_q.da_f);

    // Register writes.
    if (wr_en)
    begin
      case (addr)
        syc_pkg::A_CTRL: s_d.ctrl = wdata;
        syc_pkg::A_BAUD: s_d.baud = BRW'(wdata);
        syc_pkg::A_TXB:  s_d.txb  = wdata;
        syc_pkg::A_FLAG: clr      = wdata[syc_pkg::F_W-1:0];
        syc_pkg::A_MASK: s_d.mask = wdata[syc_pkg::F_W-1:0];
        default: ;
      endcase
    end

    // Register reads; reading the receive buffer empties it.
    if (rd_en)
    begin
      case (addr)
        syc_pkg::A_CTRL: s_d.rdata = s_q.ctrl;
        syc_pkg::A_BAUD: s_d.rdata = 16'(s_q.baud);
        syc_pkg::A_TXB:  s_d.rdata = s_q.txb;
        syc_pkg::A_RXB:
        begin
          s_d.rdata   = s_q.rxb;
          s_d.rb_full = 1'b0;
        end
        syc_pkg::A_FLAG: s_d.rdata = {10'h000, s_q.flag};
        syc_pkg::A_MASK: s_d.rdata = {10'h000, s_q.mask};
        syc_pkg::A_STAT: s_d.rdata = {7'h00, s_q.st == syc_pkg::SH_RUN, s_q.loaded,
                                      s_q.tb_full, s_q.rb_full, s_q.edge_k};
        default:         s_d.rdata = '0;
      endcase
    end

    // Cycles since the last slave clock edge, saturating.
    if (ck_edge)
      s_d.hp = '0;
    else if (s_q.hp != '1)
      s_d.hp = BRW'(s_q.hp + 1'b1);

    // Transfer start.
    if (!en_w)
    begin
      s_d.st     = syc_pkg::SH_IDLE;
      s_d.loaded = 1'b0;
      s_d.edge_k = '0;
    end
    else if (s_q.st == syc_pkg::SH_IDLE)
    begin
      if (mst_w)
      begin
        // Master starts as soon as a character waits in the buffer.
        if (s_q.tb_full)
        begin
          s_d.sr      = s_q.txb; // RULE15
          s_d.tb_full = 1'b0;
          set[syc_pkg::F_TXE] = 1'b1;
          s_d.st      = syc_pkg::SH_RUN;
          s_d.rx      = '0;
          k           = '0;
        end
      end
      else
      begin
        // Slave preloads so the first bit stands before the first edge.
        if (s_q.tb_full && !s_q.loaded)
        begin
          s_d.sr      = s_q.txb;
          s_d.tb_full = 1'b0;
          s_d.loaded  = 1'b1;
          set[syc_pkg::F_TXE] = 1'b1;
        end
        if (ck_edge && s_d.ck_f != pol_w)
        begin
          if (!s_q.loaded && !s_q.tb_full)
            set[syc_pkg::F_TE] = 1'b1; // RULE8
          s_d.st     = syc_pkg::SH_RUN; // RULE3
          s_d.loaded = 1'b0;
          s_d.rx     = '0;
          k          = '0;
          ev         = 1'b1;
        end
      end
    end
    else
      ev = mst_w ? tick : ck_edge; // RULE3

    // One shift clock edge: latch, shift, count.
    if (ev)
    begin
      latch = ph_w ? k[0] : ~k[0]; // RULE6
      shf   = ph_w ? (~k[0] && k != '0) : k[0]; // RULE6
      if (latch)
      begin
        s_d.rx = shift_in(s_d.rx, rxbit, lm1_w, msb_w); // RULE4
        if (din_chg && !lb_w)
          set[syc_pkg::F_PE] = 1'b1; // RULE9
      end
      if (shf)
        s_d.sr = msb_w ? (s_d.sr << 1) : (s_d.sr >> 1); // RULE4
      if (!mst_w && s_q.st == syc_pkg::SH_RUN && s_q.hp < (s_q.baud >> 1))
        set[syc_pkg::F_BE] = 1'b1; // RULE9
      if (mst_w)
        s_d.sclk_lvl = ~s_q.sclk_lvl;
      if (k == last_k)
      begin
        done        = 1'b1;
        s_d.st      = syc_pkg::SH_IDLE;
        s_d.edge_k  = '0;
        s_d.rxb     = s_d.rx; // RULE15
        if (s_d.rb_full)
          set[syc_pkg::F_RE] = 1'b1; // RULE8
        s_d.rb_full = 1'b1;
        set[syc_pkg::F_RXF] = 1'b1;
      end
      else
        s_d.edge_k = 5'(k + 1'b1);
    end

    // Clock rests at its idle level outside transfers.
    if (s_d.st == syc_pkg::SH_IDLE)
      s_d.sclk_lvl = pol_w; // RULE5

    // A buffer write after a same-cycle load still stands.
    if (wr_en && addr == syc_pkg::A_TXB)
      s_d.tb_full = 1'b1;

    // Sticky flags; a new event wins over a clear in the same cycle.
    s_d.flag = (s_q.flag & ~clr) | set; // RULE16

    // Pin drivers: master drives clock and the out line, slave the in line.
    tb  = tx_bit(s_d.sr, lm1_w, msb_w);
    drv = en_w && (hd_w ? ~tb : 1'b1); // RULE1
    own = mst_w ^ swap_w; // RULE13
    s_d.sclk_o  = s_d.sclk_lvl;
    s_d.sclk_oe = en_w && mst_w; // RULE3 RULE14
    s_d.pa_o    = tb;
    s_d.pa_oe   = own && drv;
    s_d.pb_o    = tb;
    s_d.pb_oe   = !own && drv;

    // Interrupt lines.
    s_d.irq_tx  = s_d.flag[syc_pkg::F_TXE] & s_d.mask[syc_pkg::F_TXE]; // RULE10
    s_d.irq_rx  = s_d.flag[syc_pkg::F_RXF] & s_d.mask[syc_pkg::F_RXF]; // RULE11
    s_d.irq_err = |(s_d.flag[syc_pkg::F_BE:syc_pkg::F_TE] & s_d.mask[syc_pkg::F_BE:syc_pkg::F_TE]);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s_q      <= '0;
      s_q.ctrl <= syc_pkg::CTRL_RST;
      s_q.baud <= BRW'(syc_pkg::BAUD_RST);
      s_q.mask <= syc_pkg::MASK_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs.
  assign rdata   = s_q.rdata;
  assign irq_tx  = s_q.irq_tx;
  assign irq_rx  = s_q.irq_rx;
  assign irq_err = s_q.irq_err;
  assign sclk_o  = s_q.sclk_o;
  assign sclk_oe = s_q.sclk_oe;
  assign pa_o    = s_q.pa_o;
  assign pa_oe   = s_q.pa_oe;
  assign pb_o    = s_q.pb_o;
  assign pb_oe   = s_q.pb_oe;

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence m_start_s;
    s_q.st == syc_pkg::SH_IDLE && en_w && mst_w && s_q.tb_full && !(wr_en && addr == syc_pkg::A_CTRL);
  endsequence

  sequence m_run_s;
    s_q.st == syc_pkg::SH_RUN && !s_q.tb_full && s_q.flag[syc_pkg::F_TXE];
  endsequence

  master_start_a: assert property (m_start_s |=> m_run_s) // RULE15
    else $error("master did not start");
  idle_clock_a: assert property (s_q.st == syc_pkg::SH_IDLE && en_w && mst_w && $stable(s_q.ctrl)
    |-> sclk_o == pol_w) // RULE5
    else $error("clock not at idle level");
  char_len_a: assert property (done |-> s_q.edge_k == last_k) // RULE2
    else $error("wrong number of edges");
  rx_full_a: assert property (done |=> s_q.rb_full && s_q.flag[syc_pkg::F_RXF]) // RULE11
    else $error("receive buffer not filled");
  overrun_a: assert property (done && s_q.rb_full && !(rd_en && addr == syc_pkg::A_RXB)
    |=> s_q.flag[syc_pkg::F_RE]) // RULE8
    else $error("overrun not flagged");
  err_sticky_a: assert property (s_q.flag[syc_pkg::F_PE] && !(wr_en && addr == syc_pkg::A_FLAG)
    |=> s_q.flag[syc_pkg::F_PE]) // RULE16
    else $error("phase error flag lost");
  irq_err_a: assert property (irq_err == |(s_q.flag[5:2] & s_q.mask[5:2])) // RULE10
    else $error("error interrupt mismatch");
  clk_tick_a: assert property (s_q.st == syc_pkg::SH_RUN && mst_w && $changed(s_q.sclk_lvl)
    |-> $past(tick)) // RULE7
    else $error("clock edge without tick");
  slave_clk_a: assert property (!mst_w |=> !sclk_oe) // RULE3
    else $error("slave drives clock");

endmodule

//--- tb/syc_spi_slave.sv
/*
  Behavioural slave peripheral on the far end of the serial link.
  Assumes the bench holds clr high while the clock line settles.
*/
`timescale 1ns/10ps
module syc_spi_slave
(
  input  wire logic        clr,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        phase,
  input  wire logic        msb,
  input  wire logic [4:0]  len,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic      [15:0] rx_word
);
  int n = 0;

  // Maps the k-th bit of a frame to its place in the word.
  function automatic int pos(input int k, input logic m, input logic [4:0] l);
    return m ? int'(l) - 1 - k : k;
  endfunction

  // A bit stands on the line until the next shift edge.
  assign miso = tx_word[pos((n - int'(phase)) / 2, msb, len)];

  // Counts edges and latches on the edge that does not shift.
  always @(sclk or posedge clr)
  begin
    if (clr)
    begin
      n = 0;
      rx_word = '0;
    end
    else
    begin
      n = n + 1;
      if ((n % 2 == 1) != phase)
        rx_word[pos((n - 1) / 2, msb, len)] = mosi;
      if (n == 2 * int'(len))
        n = 0;
    end
  end
endmodule

//--- tb/syc_channel_tb_top.sv
/*
  Self-checking bench for the channel in master mode against a slave model.
  Assumes the register map, fields and reset values of the channel package.
*/
`timescale 1ns/10ps
module syc_channel_tb_top;
  localparam logic [15:0] BASE = 16'(1 << syc_pkg::C_EN) | 16'(1 << syc_pkg::C_MST);
  logic        clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'h0;
  logic        rd_en = 1'h0;
  logic [15:0] rdata, part_rx;
  logic [15:0] ctrl_v = 16'h0000;
  logic [15:0] baud_v = 16'h0000;
  logic [15:0] part_tx = 16'h0000;
  logic        part_clr = 1'h1;
  logic        irq_tx, irq_rx, irq_err, sclk_o, sclk_oe, pa_o, pa_oe, pb_o, pb_oe;
  logic        sclk_ln, pa_ln, pb_ln, mosi, miso, swp;
  logic [4:0]  part_len;
  int          fail_count = 0;
  int          cmp_count = 0;

  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  // Pins resolved from drivers; undriven receive pin shows the slave's miso, undriven out pin its own output inverted, shared half-duplex line its pull-up.
  assign swp      = ctrl_v[syc_pkg::C_SWAP];
  assign sclk_ln  = sclk_oe ? sclk_o : ctrl_v[syc_pkg::C_POL];
  assign pa_ln    = pa_oe ? pa_o : (ctrl_v[syc_pkg::C_HALF] ? 1'h1 : (swp ? miso : ~pa_o));
  assign pb_ln    = pb_oe ? pb_o : (swp ? ~pb_o : miso);
  assign mosi     = swp ? pb_ln : pa_ln;
  assign part_len = (ctrl_v[3:0] == 4'h0) ? 5'h02 : 5'(ctrl_v[3:0]) + 5'h01;

  syc_channel #(.BRW(16)) dut
  (
    .clk     (clk),
    .reset_n (reset_n),
    .addr    (addr),
    .wdata   (wdata),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rdata   (rdata),
    .irq_tx  (irq_tx),
    .irq_rx  (irq_rx),
    .irq_err (irq_err),
    .sclk_i  (sclk_ln),
    .sclk_o  (sclk_o),
    .sclk_oe (sclk_oe),
    .pa_i    (pa_ln),
    .pa_o    (pa_o),
    .pa_oe   (pa_oe),
    .pb_i    (pb_ln),
    .pb_o    (pb_o),
    .pb_oe   (pb_oe)
  );

  syc_spi_slave part
  (
    .clr     (part_clr),
    .sclk    (sclk_ln),
    .mosi    (mosi),
    .pol     (ctrl_v[syc_pkg::C_POL]),
    .phase   (ctrl_v[syc_pkg::C_PHASE]),
    .msb     (ctrl_v[syc_pkg::C_MSB]),
    .len     (part_len),
    .tx_word (part_tx),
    .miso    (miso),
    .rx_word (part_rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    d = rdata;
  endtask

  // Sets up the channel and restarts the slave model.
  task automatic cfg(input logic [15:0] c, input logic [15:0] b);
    part_clr <= 1'h1;
    baud_v = b;
    wr(syc_pkg::A_BAUD, b);
    wr(syc_pkg::A_MASK, 16'h003f);
    wr(syc_pkg::A_CTRL, c);
    ctrl_v <= c;
    repeat (3) @(posedge clk);
    part_clr <= 1'h0;
  endtask

  // Waits a bounded time for the receive or error interrupt.
  task automatic wait_irq(input logic err);
    int i;
    for (i = 0; i < 3000 && (err ? irq_err : irq_rx) !== 1'h1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("irq_wait", 16'h0001, 16'(err ? irq_err : irq_rx));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One master transfer, judged on the wire, the slave and the registers.
  task automatic xfer(input logic [15:0] tx, input logic [15:0] ptx, input logic [15:0] erx, input logic pins);
    int l, tg, gap, gbad, i;
    logic last;
    logic [1:0] oe;
    logic [15:0] v, m;
    l = int'(part_len);
    m = 16'hffff >> (16 - l);
    tg = 0;
    gap = 0;
    gbad = 0;
    oe = 2'h0;
    last = sclk_o;
    part_tx <= ptx;
    wr(syc_pkg::A_TXB, tx);
    for (i = 0; i < 3000 && irq_rx !== 1'h1; i++)
    begin
      @(posedge clk);
      #1;
      if (sclk_o !== last)
      begin
        if (tg > 0 && gap != int'(baud_v) + 1)
          gbad++;
        if (tg == 0)
          oe = swp ? {pb_oe, pa_oe} : {pa_oe, pb_oe};
        tg++;
        gap = 0;
        last = sclk_o;
      end
      gap++;
    end
    chk("edges", 16'(2 * l), 16'(tg));
    chk("half_period", 16'h0000, 16'(gbad));
    chk("idle_clock", 16'(ctrl_v[syc_pkg::C_POL]), 16'(sclk_o));
    chk("irq_tx", 16'h0001, 16'(irq_tx));
    if (pins)
    begin
      chk("data_oe", 16'h0002, 16'(oe));
      chk("slave_rx", tx & m, part_rx & m);
    end
    rd(syc_pkg::A_FLAG, v);
    chk("flags", 16'h0003, v);
    rd(syc_pkg::A_RXB, v);
    chk("rxb", erx & m, v & m);
    wr(syc_pkg::A_FLAG, 16'h003f);
    rd(syc_pkg::A_FLAG, v);
    chk("irqs_clear", 16'h0000, {v[13:0], irq_tx, irq_rx});
  endtask

  // Reset values, unmapped address and mask readback.
  task automatic t_regs();
    logic [15:0] v;
    rd(syc_pkg::A_CTRL, v);
    chk("ctrl_rst", syc_pkg::CTRL_RST, v);
    rd(syc_pkg::A_BAUD, v);
    chk("baud_rst", syc_pkg::BAUD_RST, v);
    rd(syc_pkg::A_FLAG, v);
    chk("flag_rst", 16'h0000, v);
    rd(syc_pkg::A_STAT, v);
    chk("stat_rst", 16'h0000, v);
    wr(3'h7, 16'hffff);
    rd(3'h7, v);
    chk("unmapped", 16'h0000, v);
    wr(syc_pkg::A_MASK, 16'h002a);
    rd(syc_pkg::A_MASK, v);
    chk("mask", 16'h002a, v);
    chk("sclk_oe", 16'h0000, 16'(sclk_oe));
  endtask

  // All polarity, phase and order settings.
  task automatic t_modes();
    int k;
    for (k = 0; k < 8; k++)
    begin
      cfg(BASE | 16'h0007 | 16'(k << syc_pkg::C_MSB), 16'h0004);
      xfer(16'h00b1 ^ 16'(k), 16'h004e ^ 16'(k << 4), 16'h004e ^ 16'(k << 4), 1'h1);
    end
  endtask

  // Shortest, field-zero and longest characters.
  task automatic t_len();
    int lm[3] = '{0, 1, 15};
    int k;
    for (k = 0; k < 3; k++)
    begin
      cfg(BASE | 16'(lm[k]) | 16'(1 << syc_pkg::C_MSB), 16'h0004);
      xfer(16'hc3a6, 16'h5b2d, 16'h5b2d, 1'h1);
    end
  endtask

  // Loop-back at the top rate, swapped data pins, then half duplex on the shared line.
  task automatic t_loop_swap();
    cfg(BASE | 16'h0007 | 16'(1 << syc_pkg::C_LOOP), 16'h0000);
    xfer(16'h0096, 16'h0069, 16'h0096, 1'h0);
    cfg(BASE | 16'h0007 | 16'(1 << syc_pkg::C_SWAP), 16'h0004);
    xfer(16'h00e4, 16'h001b, 16'h001b, 1'h1);
    cfg(BASE | 16'h0007 | 16'(1 << syc_pkg::C_HALF), 16'h0004);
    xfer(16'h00a6, 16'h0000, 16'h00a6, 1'h1);
  endtask

  // Receive overrun: error flag, interrupt, mask and sticky clear.
  task automatic t_err();
    logic [15:0] v;
    cfg(BASE | 16'h0007, 16'h0004);
    part_tx <= 16'h0055;
    wr(syc_pkg::A_TXB, 16'h0011);
    wait_irq(1'h0);
    wr(syc_pkg::A_FLAG, 16'h0003);
    wr(syc_pkg::A_TXB, 16'h0022);
    wait_irq(1'h1);
    wr(syc_pkg::A_MASK, 16'h0037);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_err_masked", 16'h0000, 16'(irq_err));
    rd(syc_pkg::A_FLAG, v);
    chk("re_sticky", 16'h0008, v & 16'h0008);
    wr(syc_pkg::A_FLAG, 16'h0008);
    rd(syc_pkg::A_FLAG, v);
    chk("re_cleared", 16'h0000, v & 16'h0008);
    rd(syc_pkg::A_RXB, v);
    wr(syc_pkg::A_FLAG, 16'h003f);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence after ten cycles of reset.
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    t_regs();
    t_modes();
    t_len();
    t_loop_swap();
    t_err();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length.
  initial
  begin
    #(25 * 60000);
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
